// file: design/mlb_pkg.sv
// Constants, word layout and state codes for the multi-lane bonding block.
// Assumes lane words are one control flag plus one data byte.
package mlb_pkg;

   localparam int MLB_DW = 8;
   localparam int MLB_NUMW = 4;
   // Lane words below the minimum would let a one-word skew overrun a lane FIFO
   localparam int MLB_FIFO_MIN = 3;
   localparam int MLB_RX_DEPTH = 4;
   localparam int MLB_TX_DEPTH = 2;
   localparam int MLB_SYNC_WAIT_CYC = 64;

   // Control word kinds, upper nibble of a control word's data byte
   localparam logic [3:0] MLB_KIND_IDLE = 4'h0;
   localparam logic [3:0] MLB_KIND_SYNC = 4'h1;
   localparam logic [3:0] MLB_KIND_FAULT = 4'h2;

   localparam logic [MLB_NUMW-1:0] MLB_NULL_NUM = 4'h0;
   localparam logic [MLB_NUMW-1:0] MLB_FIRST_NUM = 4'h1;
   localparam logic [MLB_NUMW-1:0] MLB_ONE_LANE = 4'h1;
   localparam logic MLB_RETRY_LIMIT = 1'h1;

   typedef struct packed {
      logic ctrl;
      logic [MLB_DW-1:0] data;
   } mlb_word_t;

   typedef struct packed {
      logic [3:0] kind;
      logic [MLB_NUMW-1:0] num;
   } mlb_ctrl_t;

   typedef struct packed {
      logic synced;
      logic perm_error;
      logic [MLB_NUMW-1:0] used_lanes;
   } mlb_status_t;

   // Gray along send -> wait -> run -> reinit -> fail; wait to reinit or fail changes more than one bit
   typedef enum logic [2:0] {
      MLB_ST_SEND = 3'h0,
      MLB_ST_WAIT = 3'h1,
      MLB_ST_RUN = 3'h3,
      MLB_ST_REINIT = 3'h2,
      MLB_ST_FAIL = 3'h6
   } mlb_state_t;

   localparam mlb_word_t MLB_IDLE_WORD = '{ctrl: 1'b1, data: {MLB_KIND_IDLE, MLB_NULL_NUM}};

endpackage

// file: design/mlb_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; read data is taken straight from storage flops.
`timescale 1ns/100ps
`default_nettype none
module mlb_fifo
   import mlb_pkg::*;
#(
   parameter int W = 9,
   parameter int DEPTH = 2
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

   logic [W-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wr_ptr_ff;
   logic [AW-1:0] rd_ptr_ff;
   logic [AW:0] cnt_ff;
   logic push;
   logic pop;

   assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
   assign out_valid = (cnt_ff != '0);
   assign out_data = mem_ff[rd_ptr_ff];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_ff[wr_ptr_ff] <= in_data;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         cnt_ff <= '0;
      end else begin
         if (push) begin
            wr_ptr_ff <= (wr_ptr_ff == LAST) ? '0 : wr_ptr_ff + AW'(1);
         end
         if (pop) begin
            rd_ptr_ff <= (rd_ptr_ff == LAST) ? '0 : rd_ptr_ff + AW'(1);
         end
         cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   // R16 depth never exceeded
   a_fifo_no_overrun: assert property (@(posedge clk_sys) disable iff (srst) // R16
      (cnt_ff == (AW+1)'(DEPTH)) |-> !in_ready ##1 $stable(wr_ptr_ff))
      else $error("FIFO written while full");

endmodule
`default_nettype wire

// file: design/mlb_bond.sv
// Multi-lane bonding: lane numbering, lane sync exchange, distribution
// of the word stream over used lanes and concentration back from lanes.
// Assumes lane layer and upper layer logic share clk_sys; per-lane
// receive never stalls long, so full lane FIFOs show as lane_rx_ready low.
// Contract
// R1 - Used lanes: smaller of required, active
// R2 - Physical lane indices count up from one
// R3 - Setting or active change starts resynchronisation
// R4 - Lowest active lanes get numbers 1, 2...
// R5 - Remaining active lanes get number zero
// R6 - Sync word with number on each active lane
// R7 - Sync words on all lanes together
// R8 - Distribute data only after sync sent
// R9 - Receiver waits for sync on all lanes
// R10 - Concentrator uses lanes with nonzero numbers
// R11 - Missing sync on a lane: reinitialise all
// R12 - Bad number series: reinitialise all lanes
// R13 - Failure after reinit: permanent error, notify
// R14 - Round robin over used lanes, lowest first
// R15 - Standby lanes carry no data words
// R16 - One FIFO per lane, three words minimum
// R17 - Concentrator reads lanes in number order
// R18 - Bypass mode runs one lane only
// R19 - One retry, cleared after successful sync
`timescale 1ns/100ps
`default_nettype none
module mlb_bond
   import mlb_pkg::*;
#(
   parameter int NL = 4,
   parameter int RX_DEPTH = MLB_RX_DEPTH,
   parameter int SYNC_WAIT_CYC = MLB_SYNC_WAIT_CYC
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic [MLB_NUMW-1:0] req_lanes,
   input wire logic [NL-1:0] lane_active,
   input wire logic bypass,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire mlb_word_t tx_word,
   output mlb_word_t [NL-1:0] lane_tx_word,
   output logic [NL-1:0] lane_tx_valid,
   input wire logic [NL-1:0] lane_tx_ready,
   input wire mlb_word_t [NL-1:0] lane_rx_word,
   input wire logic [NL-1:0] lane_rx_valid,
   output logic [NL-1:0] lane_rx_ready,
   output logic rx_valid,
   input wire logic rx_ready,
   output mlb_word_t rx_word,
   output logic lane_reinit,
   output mlb_status_t status
);
   localparam int LW = (NL > 1) ? $clog2(NL) : 1;
   localparam int WW = $bits(mlb_word_t);
   localparam logic [15:0] WAIT_LAST = 16'(SYNC_WAIT_CYC - 1);

   mlb_state_t state_ff;
   logic [MLB_NUMW-1:0] act_cnt;
   logic [MLB_NUMW-1:0] used_calc;
   logic [MLB_NUMW-1:0] used_ff;
   logic [NL-1:0][MLB_NUMW-1:0] nxt_tx_num;
   logic [NL-1:0][MLB_NUMW-1:0] tx_num_ff;
   logic [NL-1:0][LW-1:0] nxt_tx_map;
   logic [NL-1:0][LW-1:0] tx_map_ff;
   logic [MLB_NUMW-1:0] asg_cnt;
   logic [MLB_NUMW-1:0] prev_req_ff;
   logic [NL-1:0] prev_act_ff;
   logic prev_bypass_ff;
   logic chg;
   logic load_sync;
   mlb_word_t [NL-1:0] tx_word_ff;
   logic [NL-1:0] tx_vld_ff;
   logic buf_valid;
   logic buf_ready;
   logic [WW-1:0] buf_data;
   logic dist_fire;
   logic [LW-1:0] dist_lane;
   logic [MLB_NUMW-1:0] tx_ptr_ff;
   logic [NL-1:0] got_ff;
   logic [NL-1:0] fault_ff;
   logic [NL-1:0][MLB_NUMW-1:0] rx_num_ff;
   logic [NL-1:0] rx_is_sync;
   logic [NL-1:0] rx_is_fault;
   logic all_in;
   logic seq_ok;
   logic sync_pass;
   logic sync_fail;
   logic wait_expired;
   logic [15:0] wait_cnt_ff;
   logic [MLB_NUMW-1:0] nz_cnt;
   logic [MLB_NUMW-1:0] hits;
   logic gap_seen;
   logic [NL-1:0][LW-1:0] rx_map_calc;
   logic [NL-1:0][LW-1:0] rx_map_ff;
   logic [MLB_NUMW-1:0] rx_used_ff;
   logic [MLB_NUMW-1:0] rx_ptr_ff;
   logic [LW-1:0] rx_lane;
   logic rx_fire;
   logic retry_ff;
   logic perm_ff;
   logic reinit_ff;
   logic [NL-1:0] fifo_valid;
   logic [NL-1:0] fifo_pop;
   logic [NL-1:0][WW-1:0] fifo_data;

   // R1 smaller setting wins
   // R18 bypass forces one lane
   always_comb begin
      act_cnt = '0;
      for (int i = 0; i < NL; i++) begin
         act_cnt = act_cnt + MLB_NUMW'(lane_active[i]);
      end
      if (bypass) begin
         used_calc = (act_cnt != '0) ? MLB_ONE_LANE : '0;
      end else begin
         used_calc = (req_lanes <= act_cnt) ? req_lanes : act_cnt;
      end
   end

   // R2 index i is physical lane i+1
   // R4 lowest active lanes numbered
   // R5 leftover active lanes zero
   always_comb begin
      asg_cnt = '0;
      nxt_tx_num = '0;
      nxt_tx_map = '0;
      for (int i = 0; i < NL; i++) begin
         if (lane_active[i] && (asg_cnt < used_calc)) begin
            nxt_tx_num[i] = asg_cnt + MLB_FIRST_NUM;
            nxt_tx_map[asg_cnt] = LW'(i);
            asg_cnt = asg_cnt + MLB_FIRST_NUM;
         end
      end
   end

   // R3 change detection
   assign chg = (req_lanes != prev_req_ff) || (lane_active != prev_act_ff) ||
                (bypass != prev_bypass_ff);

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         prev_req_ff <= '0;
         prev_act_ff <= '0;
         prev_bypass_ff <= 1'b0;
      end else begin
         prev_req_ff <= req_lanes;
         prev_act_ff <= lane_active;
         prev_bypass_ff <= bypass;
      end
   end

   // R7 all active lanes drained, then loaded in the same cycle
   assign load_sync = (state_ff == MLB_ST_SEND) && (act_cnt != '0) &&
                      ((tx_vld_ff & lane_active) == '0);

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         used_ff <= '0;
         tx_num_ff <= '0;
         tx_map_ff <= '0;
      end else if (load_sync) begin
         used_ff <= used_calc;
         tx_num_ff <= nxt_tx_num;
         tx_map_ff <= nxt_tx_map;
      end
   end

   // Upper layer stalls here during resync instead of losing a word
   mlb_fifo #(.W(WW), .DEPTH(MLB_TX_DEPTH)) u_tx_buf (
      .clk_sys(clk_sys),
      .srst(srst),
      .in_valid(tx_valid),
      .in_ready(tx_ready),
      .in_data(tx_word),
      .out_valid(buf_valid),
      .out_ready(buf_ready),
      .out_data(buf_data)
   );

   // R14 round robin target
   assign dist_lane = tx_map_ff[tx_ptr_ff];
   // R8 only once sync is out
   assign buf_ready = ((state_ff == MLB_ST_WAIT) || (state_ff == MLB_ST_RUN)) &&
                      (used_ff != '0) &&
                      (!tx_vld_ff[dist_lane] || lane_tx_ready[dist_lane]);
   assign dist_fire = buf_valid && buf_ready;

   always_ff @(posedge clk_sys) begin
      if (srst || load_sync) begin
         tx_ptr_ff <= '0;
      end else if (dist_fire) begin
         tx_ptr_ff <= (tx_ptr_ff + MLB_FIRST_NUM >= used_ff) ? '0 : tx_ptr_ff + MLB_FIRST_NUM;
      end
   end

   // R6 sync word per active lane
   // R15 only mapped lanes get data
   always_ff @(posedge clk_sys) begin
      for (int i = 0; i < NL; i++) begin
         if (srst) begin
            tx_vld_ff[i] <= 1'b0;
            tx_word_ff[i] <= MLB_IDLE_WORD;
         end else if (load_sync && lane_active[i]) begin
            tx_vld_ff[i] <= 1'b1;
            tx_word_ff[i] <= '{ctrl: 1'b1, data: {MLB_KIND_SYNC, nxt_tx_num[i]}};
         end else if (dist_fire && (dist_lane == LW'(i))) begin
            tx_vld_ff[i] <= 1'b1;
            tx_word_ff[i] <= buf_data;
         end else if (lane_tx_ready[i]) begin
            tx_vld_ff[i] <= 1'b0;
         end
      end
   end

   assign lane_tx_valid = tx_vld_ff;
   assign lane_tx_word = tx_word_ff;

   // R9 catch sync words per lane
   always_comb begin
      for (int i = 0; i < NL; i++) begin
         rx_is_sync[i] = lane_rx_valid[i] && lane_rx_word[i].ctrl &&
                         (lane_rx_word[i].data[MLB_DW-1:MLB_NUMW] == MLB_KIND_SYNC);
         rx_is_fault[i] = lane_rx_valid[i] && lane_rx_word[i].ctrl &&
                          (lane_rx_word[i].data[MLB_DW-1:MLB_NUMW] == MLB_KIND_FAULT);
      end
   end

   // A sync arriving with the clear is kept: set wins
   always_ff @(posedge clk_sys) begin
      for (int i = 0; i < NL; i++) begin
         if (srst) begin
            got_ff[i] <= 1'b0;
            fault_ff[i] <= 1'b0;
            rx_num_ff[i] <= '0;
         end else if (rx_is_sync[i]) begin
            got_ff[i] <= 1'b1;
            rx_num_ff[i] <= lane_rx_word[i].data[MLB_NUMW-1:0];
         end else if (sync_pass || sync_fail) begin
            got_ff[i] <= 1'b0;
            fault_ff[i] <= rx_is_fault[i];
         end else if (rx_is_fault[i] && (got_ff != '0)) begin
            fault_ff[i] <= 1'b1;
         end
      end
   end

   // R12 series check, duplicate zeros allowed
   always_comb begin
      nz_cnt = '0;
      hits = '0;
      gap_seen = 1'b0;
      seq_ok = 1'b1;
      rx_map_calc = '0;
      for (int i = 0; i < NL; i++) begin
         if (got_ff[i] && (rx_num_ff[i] != MLB_NULL_NUM)) begin
            nz_cnt = nz_cnt + MLB_FIRST_NUM;
            if (rx_num_ff[i] > MLB_NUMW'(NL)) begin
               seq_ok = 1'b0;
            end
         end
      end
      for (int k = 1; k <= NL; k++) begin
         hits = '0;
         for (int i = 0; i < NL; i++) begin
            if (got_ff[i] && (rx_num_ff[i] == MLB_NUMW'(k))) begin
               hits = hits + MLB_FIRST_NUM;
               rx_map_calc[k-1] = LW'(i);
            end
         end
         if (hits > MLB_FIRST_NUM || (gap_seen && hits != '0)) begin
            seq_ok = 1'b0;
         end
         if (hits == '0) begin
            gap_seen = 1'b1;
         end
      end
      if (nz_cnt == '0) begin
         seq_ok = 1'b0;
      end
   end

   assign all_in = (got_ff != '0) && ((got_ff | ~lane_active) == '1);
   assign wait_expired = (got_ff != '0) && !all_in && (wait_cnt_ff == WAIT_LAST);
   // R10 decide once every active lane reported
   assign sync_pass = (state_ff == MLB_ST_WAIT) && all_in && seq_ok && (fault_ff == '0);
   // R11 missing lane times out
   assign sync_fail = (state_ff == MLB_ST_WAIT) && !chg &&
                      ((all_in && (!seq_ok || fault_ff != '0)) || wait_expired);

   always_ff @(posedge clk_sys) begin
      if (srst || got_ff == '0 || sync_pass || sync_fail) begin
         wait_cnt_ff <= '0;
      end else if (wait_cnt_ff != WAIT_LAST) begin
         wait_cnt_ff <= wait_cnt_ff + 16'h0001;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state_ff <= MLB_ST_SEND;
      end else begin
         unique case (state_ff)
            MLB_ST_SEND: begin
               if (load_sync) begin
                  state_ff <= MLB_ST_WAIT;
               end
            end
            // R3 resync on change
            MLB_ST_WAIT: begin
               if (chg) begin
                  state_ff <= MLB_ST_SEND;
               end else if (sync_pass) begin
                  state_ff <= MLB_ST_RUN;
               end else if (sync_fail) begin
                  state_ff <= (retry_ff == MLB_RETRY_LIMIT) ? MLB_ST_FAIL : MLB_ST_REINIT;
               end
            end
            MLB_ST_RUN: begin
               if (chg) begin
                  state_ff <= MLB_ST_SEND;
               end else if (got_ff != '0) begin
                  state_ff <= MLB_ST_WAIT;
               end
            end
            MLB_ST_REINIT: begin
               state_ff <= MLB_ST_SEND;
            end
            MLB_ST_FAIL: begin
               state_ff <= MLB_ST_FAIL;
            end
            default: begin
               state_ff <= MLB_ST_SEND;
            end
         endcase
      end
   end

   // R19 single retry, cleared on pass
   // R13 second failure is permanent
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         retry_ff <= 1'b0;
         perm_ff <= 1'b0;
         reinit_ff <= 1'b0;
      end else begin
         reinit_ff <= sync_fail && (retry_ff != MLB_RETRY_LIMIT);
         if (sync_pass) begin
            retry_ff <= 1'b0;
         end else if (sync_fail) begin
            retry_ff <= MLB_RETRY_LIMIT;
         end
         if (sync_fail && (retry_ff == MLB_RETRY_LIMIT)) begin
            perm_ff <= 1'b1;
         end
      end
   end

   // R10 concentrator set from received numbers
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rx_map_ff <= '0;
         rx_used_ff <= '0;
      end else if (sync_pass) begin
         rx_map_ff <= rx_map_calc;
         rx_used_ff <= nz_cnt;
      end
   end

   // R16 one sync FIFO per lane
   for (genvar g = 0; g < NL; g++) begin : g_lane
      mlb_fifo #(.W(WW), .DEPTH(RX_DEPTH)) u_rx_fifo (
         .clk_sys(clk_sys),
         .srst(srst),
         .in_valid(lane_rx_valid[g] && !rx_is_sync[g]),
         .in_ready(lane_rx_ready[g]),
         .in_data(lane_rx_word[g]),
         .out_valid(fifo_valid[g]),
         .out_ready(fifo_pop[g]),
         .out_data(fifo_data[g])
      );
      assign fifo_pop[g] = rx_fire && (rx_lane == LW'(g));
   end

   // R17 read in received number order
   assign rx_lane = rx_map_ff[rx_ptr_ff];
   assign rx_valid = (state_ff == MLB_ST_RUN) && (rx_used_ff != '0) && fifo_valid[rx_lane];
   assign rx_word = fifo_data[rx_lane];
   assign rx_fire = rx_valid && rx_ready;

   always_ff @(posedge clk_sys) begin
      if (srst || sync_pass) begin
         rx_ptr_ff <= '0;
      end else if (rx_fire) begin
         rx_ptr_ff <= (rx_ptr_ff + MLB_FIRST_NUM >= rx_used_ff) ? '0 : rx_ptr_ff + MLB_FIRST_NUM;
      end
   end

   assign lane_reinit = reinit_ff;
   assign status = '{synced: (state_ff == MLB_ST_RUN), perm_error: perm_ff, used_lanes: used_ff};

   // Assertions
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   a_used_lane_min: assert property (load_sync && !bypass |-> // R1
      used_calc <= req_lanes && used_calc <= act_cnt &&
      (used_calc == req_lanes || used_calc == act_cnt))
      else $error("Used lane count not the minimum");
   a_bypass_one_lane: assert property (load_sync && bypass |=> used_ff == MLB_ONE_LANE) // R18
      else $error("Bypass did not select one lane");
   a_sync_all_lanes: assert property (load_sync |=> // R7
      ((tx_vld_ff & $past(lane_active)) == $past(lane_active)) && state_ff == MLB_ST_WAIT)
      else $error("Sync words not loaded on all active lanes");
   a_no_early_data: assert property (dist_fire |-> state_ff != MLB_ST_SEND && // R8
      (!lane_tx_valid[dist_lane] || lane_tx_ready[dist_lane]))
      else $error("Data distributed before sync sent");
   a_standby_no_data: assert property (dist_fire |-> tx_num_ff[dist_lane] != MLB_NULL_NUM) // R15
      else $error("Data placed on a standby lane");
   a_change_resync: assert property (chg && (state_ff == MLB_ST_RUN) |=> // R3
      state_ff == MLB_ST_SEND ##1 (state_ff == MLB_ST_SEND || state_ff == MLB_ST_WAIT))
      else $error("Setting change did not resynchronise");
   a_reinit_once: assert property (sync_fail && !retry_ff |=> reinit_ff ##1 !reinit_ff && // R11
      state_ff == MLB_ST_SEND)
      else $error("Reinitialise not a single pulse");
   a_retry_then_perm: assert property (sync_fail && retry_ff |=> // R19
      perm_ff && !reinit_ff && state_ff == MLB_ST_FAIL)
      else $error("Second failure not permanent");
   a_perm_sticky: assert property (perm_ff |=> perm_ff && status.perm_error) // R13
      else $error("Permanent error dropped");
   a_rx_order: assert property (rx_fire && rx_used_ff > MLB_ONE_LANE && // R17
      rx_ptr_ff == '0 |=> rx_ptr_ff == MLB_FIRST_NUM)
      else $error("Concentrator skipped a lane");

   c_sync_pass: cover property (sync_pass ##1 state_ff == MLB_ST_RUN);
   c_reinit: cover property (reinit_ff);
   c_perm: cover property ($rose(perm_ff));
   c_rx_stream: cover property (rx_fire ##1 rx_fire);

endmodule
`default_nettype wire

// file: tb/mlb_lane_model.sv
// Lane layer stand-in: takes lane words and loops each one back as received.
// Assumes the bench chooses stalling and which lanes lose or corrupt words.
`timescale 1ns/100ps
`default_nettype none
module mlb_lane_model
   import mlb_pkg::*;
#(
   parameter int NL = 4
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic slow,
   input wire logic [NL-1:0] drop_mask,
   input wire logic [NL-1:0] dup_mask,
   input wire mlb_word_t [NL-1:0] lane_tx_word,
   input wire logic [NL-1:0] lane_tx_valid,
   output logic [NL-1:0] lane_tx_ready,
   output mlb_word_t [NL-1:0] lane_rx_word,
   output logic [NL-1:0] lane_rx_valid
);
   logic phase_ff;
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         phase_ff <= 1'b0;
      end else begin
         phase_ff <= ~phase_ff;
      end
   end
   // Slow mode takes a word only every other cycle, so the buffer must hold
   assign lane_tx_ready = slow ? {NL{phase_ff}} : {NL{1'b1}};
   always_ff @(posedge clk_sys) begin
      for (int i = 0; i < NL; i++) begin
         if (!srst && lane_tx_valid[i] && lane_tx_ready[i] && !drop_mask[i]) begin
            lane_rx_valid[i] <= 1'b1;
            // Corrupt sync numbers only where a scenario asks for it
            lane_rx_word[i] <= (dup_mask[i] && lane_tx_word[i].ctrl &&
                               lane_tx_word[i].data[7:4] == MLB_KIND_SYNC) ?
                               mlb_word_t'{ctrl: 1'b1, data: {MLB_KIND_SYNC, MLB_FIRST_NUM}} :
                               lane_tx_word[i];
         end else begin
            lane_rx_valid[i] <= 1'b0;
            // An idle line never repeats the last word
            lane_rx_word[i] <= ~lane_rx_word[i];
         end
      end
   end
endmodule
`default_nettype wire

// file: tb/mlb_bond_test.sv
// Self-checking bench for the bonding block, lanes looped back by a model.
// Assumes one clock and that words return on the lane they left by.
`timescale 1ns/100ps
`default_nettype none
module mlb_bond_test;
   import mlb_pkg::*;
   localparam int NL = 4;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic [MLB_NUMW-1:0] req_lanes = '0;
   logic [NL-1:0] lane_active = '0;
   logic bypass = 1'b0;
   logic tx_valid = 1'b0;
   logic rx_ready = 1'b1;
   logic slow = 1'b0;
   logic [NL-1:0] drop_mask = '0;
   logic [NL-1:0] dup_mask = '0;
   mlb_word_t tx_word = '0;
   mlb_word_t rx_word;
   mlb_word_t [NL-1:0] lane_tx_word;
   mlb_word_t [NL-1:0] lane_rx_word;
   logic [NL-1:0] lane_tx_valid, lane_tx_ready, lane_rx_valid, lane_rx_ready;
   logic tx_ready, rx_valid, lane_reinit;
   mlb_status_t status;
   int num_errors = 0;
   int checks_done = 0;
   int reinit_cnt = 0;
   int stalls = 0;
   int tx_lanes[$];
   logic [8:0] rx_data[$];

   always #4 clk_sys = ~clk_sys;

   mlb_bond #(.NL(NL), .RX_DEPTH(4), .SYNC_WAIT_CYC(8)) i_mlb_bond (
      .clk_sys(clk_sys), .srst(srst), .req_lanes(req_lanes), .lane_active(lane_active),
      .bypass(bypass), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_word(tx_word),
      .lane_tx_word(lane_tx_word), .lane_tx_valid(lane_tx_valid),
      .lane_tx_ready(lane_tx_ready), .lane_rx_word(lane_rx_word),
      .lane_rx_valid(lane_rx_valid), .lane_rx_ready(lane_rx_ready), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .rx_word(rx_word), .lane_reinit(lane_reinit), .status(status));

   mlb_lane_model #(.NL(NL)) i_mlb_lane_model (
      .clk_sys(clk_sys), .srst(srst), .slow(slow), .drop_mask(drop_mask),
      .dup_mask(dup_mask), .lane_tx_word(lane_tx_word), .lane_tx_valid(lane_tx_valid),
      .lane_tx_ready(lane_tx_ready), .lane_rx_word(lane_rx_word),
      .lane_rx_valid(lane_rx_valid));

   // Handshakes seen at the falling edge are those taken at the next rising one
   always @(negedge clk_sys) begin
      if (lane_reinit === 1'b1) reinit_cnt++;
      if (rx_valid === 1'b1 && rx_ready) rx_data.push_back(rx_word);
      for (int i = 0; i < NL; i++) begin
         if (lane_tx_valid[i] && lane_tx_ready[i] && lane_tx_word[i].ctrl === 1'b0) begin
            tx_lanes.push_back(i);
         end
      end
   end

   task automatic wrap_up();
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // 0 synced, 1 any lane word, 2 rx words, 3 reinit pulses, 4 permanent error
   task automatic wait_for(input int what, input int cnt);
      bit hit;
      hit = 1'b0;
      for (int n = 0; n < 400 && !hit; n++) begin
         @(negedge clk_sys);
         case (what)
            0: hit = (status.synced === 1'b1);
            1: hit = ((|lane_tx_valid) === 1'b1);
            2: hit = (rx_data.size() >= cnt);
            3: hit = (reinit_cnt >= cnt);
            default: hit = (status.perm_error === 1'b1);
         endcase
      end
      if (!hit) begin
         check("wait", 1, 0);
         wrap_up();
      end
   endtask

   task automatic expect_sync(input logic [NL-1:0] mask, input logic [15:0] nums,
                              input logic [3:0] used);
      wait_for(1, 0);
      check("sync lanes", mask, lane_tx_valid);
      check("used lanes", used, status.used_lanes);
      for (int i = 0; i < NL; i++) begin
         if (mask[i]) check("sync word", {1'b1, MLB_KIND_SYNC, nums[4*i +: 4]}, lane_tx_word[i]);
      end
      wait_for(0, 0);
   endtask

   task automatic flow(input int n, input logic [7:0] base, input logic [31:0] lanes);
      tx_lanes.delete();
      rx_data.delete();
      @(posedge clk_sys);
      for (int w = 0; w < n; w++) begin
         tx_valid <= 1'b1;
         tx_word <= '{ctrl: 1'b0, data: base + w[7:0]};
         @(negedge clk_sys);
         for (int k = 0; k < 50 && tx_ready !== 1'b1; k++) begin
            stalls++;
            @(negedge clk_sys);
         end
         if (tx_ready !== 1'b1) begin
            check("tx ready", 1, 0);
            wrap_up();
         end
         @(posedge clk_sys);
      end
      tx_valid <= 1'b0;
      wait_for(2, n);
      check("lane words", n, tx_lanes.size());
      for (int w = 0; w < n; w++) begin
         check("data lane", lanes[4*w +: 4], tx_lanes[w]);
         check("rx data", {1'b0, base + w[7:0]}, rx_data[w]);
      end
   endtask

   task automatic test_reset();
      repeat (7) @(posedge clk_sys);
      @(negedge clk_sys);
      check("reset status", 0, status);
      check("reset ready", 1, tx_ready);
      check("reset lane ready", 4'hf, lane_rx_ready);
      @(posedge clk_sys);
      srst <= 1'b0;
   endtask

   task automatic test_four_active();
      req_lanes <= 4'h2;
      lane_active <= 4'hf;
      expect_sync(4'hf, 16'h0021, 4'h2);
      flow(5, 8'h10, 32'h00001010);
   endtask

   task automatic test_sparse();
      @(posedge clk_sys);
      req_lanes <= 4'h4;
      lane_active <= 4'ha;
      expect_sync(4'ha, 16'h2010, 4'h2);
      flow(4, 8'h20, 32'h00003131);
   endtask

   task automatic test_bypass();
      @(posedge clk_sys);
      bypass <= 1'b1;
      slow <= 1'b1;
      stalls = 0;
      expect_sync(4'ha, 16'h0010, 4'h1);
      flow(5, 8'h30, 32'h00011111);
      check("stall seen", 1, stalls > 0);
   endtask

   task automatic test_faults();
      @(posedge clk_sys);
      srst <= 1'b1;
      @(posedge clk_sys);
      srst <= 1'b0;
      bypass <= 1'b0;
      slow <= 1'b0;
      req_lanes <= 4'h2;
      lane_active <= 4'h3;
      dup_mask <= 4'h3;
      reinit_cnt = 0;
      wait_for(3, 1);
      @(posedge clk_sys);
      dup_mask <= 4'h0;
      wait_for(0, 0);
      @(posedge clk_sys);
      drop_mask <= 4'h2;
      req_lanes <= 4'h3;
      wait_for(3, 2);
      check("synced", 0, status.synced);
      check("early perm", 0, status.perm_error);
      wait_for(4, 0);
      check("reinit count", 2, reinit_cnt);
   endtask

   initial begin
      test_reset();
      test_four_active();
      test_sparse();
      test_bypass();
      test_faults();
      wrap_up();
   end
endmodule
`default_nettype wire
